// [hdl/sbst_map.svh]
// What this block does
// - Opcode 000: capture ring, chain, outputs float
// - Opcode 001: identity word between TDI/TDO
// - Opcode 010: capture ring, chain, outputs float
// - Opcode 100: sample/preload, memory unaffected
// - Opcode 111: one-bit bypass, memory unaffected
// - Boundary chain is 89 cells long
// - Identity word 32 bits, revision bits 31:29
// - Bits 28:24 fixed internal-use field
// - Bits 23:18 fixed memory type field
// - Bits 17:12 fixed width/density code
// - Bits 11:1 fixed maker code
// - Identity bit 0 always one
// - Test-logic-reset loads identification instruction
// - New instruction applies at Update-IR only
`ifndef SBST_MAP_SVH
`define SBST_MAP_SVH
`define SBST_IR_W 3
`define SBST_OP_EXTEST 3'h0
`define SBST_OP_IDCODE 3'h1
`define SBST_OP_SAMPZ 3'h2
`define SBST_OP_SAMPLE 3'h4
`define SBST_OP_BYPASS 3'h7
`define SBST_CHAIN_LEN 89
`define SBST_ID_W 32
`define SBST_ID_REV_LSB 29
`define SBST_ID_INT_LSB 24
`define SBST_ID_TYPE_LSB 18
`define SBST_ID_DEV_LSB 12
`define SBST_ID_MAKER_LSB 1
`define SBST_IR_CAPTURE 3'h1
`endif

// [hdl/sbst_pkg.sv]
package sbst_pkg;
    typedef enum logic [3:0] {
        SBST_RESET = 4'h0, SBST_IDLE = 4'h1, SBST_SEL_DR = 4'h3, SBST_CAP_DR = 4'h2,
        SBST_SHIFT_DR = 4'h6, SBST_EXIT1_DR = 4'h7, SBST_PAUSE_DR = 4'h5, SBST_EXIT2_DR = 4'h4,
        SBST_UPD_DR = 4'hc, SBST_SEL_IR = 4'hd, SBST_CAP_IR = 4'hf, SBST_SHIFT_IR = 4'he,
        SBST_EXIT1_IR = 4'ha, SBST_PAUSE_IR = 4'hb, SBST_EXIT2_IR = 4'h9, SBST_UPD_IR = 4'h8
    } sbst_state_t;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sbst_link_t;
    typedef struct packed {
        logic rise;
        logic fall;
        logic tms;
        logic tdi;
    } sbst_edge_t;
endpackage

// [hdl/sbst_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser plus TCK edge finder
module sbst_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire sbst_pkg::sbst_link_t pins,
    output sbst_pkg::sbst_edge_t ev
);
    sbst_pkg::sbst_link_t meta_q, sync_q, last_q;
    // Synchronise pins; logic reads sync_q and last_q, never meta_q
    always_ff @(posedge sys_clk or negedge rst_n) begin
        // Reset to the idle pin levels so release brings no false TCK edge
        if (!rst_n) begin
            meta_q <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};
            sync_q <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};
            last_q <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    // Edge strobes with sampled TMS and TDI
    always_comb begin
        ev.rise = sync_q.tck & ~last_q.tck;
        ev.fall = ~sync_q.tck & last_q.tck;
        ev.tms = sync_q.tms;
        ev.tdi = sync_q.tdi;
    end
endmodule

// [hdl/sbst_chain.sv]
`timescale 1ns/1ps
`include "sbst_map.svh"
// Boundary scan chain with capture, shift and update latches
module sbst_chain #(
    parameter int LEN = `SBST_CHAIN_LEN
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic tdi,
    input wire logic [LEN-1:0] ring_in,
    output logic [LEN-1:0] preload,
    output logic so
);
    logic [LEN-1:0] sr_q, sr_d, pl_q, pl_d;
    // Refuse a chain too short for the drive-control cell
    if (LEN < 2) begin : g_len_chk
        $error("chain too short");
    end
    // One cell per ring bit; top cell is the output-drive control
    genvar i;
    generate
        for (i = 0; i < LEN; i++) begin : g_cell
            always_comb begin
                sr_d[i] = sr_q[i];
                pl_d[i] = pl_q[i];
                if (capture) begin
                    sr_d[i] = ring_in[i];
                end else if (shift) begin
                    sr_d[i] = (i == LEN - 1) ? tdi : sr_q[(i + 1) % LEN];
                end
                if (update) begin
                    pl_d[i] = sr_q[i];
                end
            end
        end
    endgenerate
    // Register cells; control cell preset high
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_q <= '0;
            pl_q <= {1'b1, {(LEN - 1){1'b0}}};
        end else begin
            sr_q <= sr_d;
            pl_q <= pl_d;
        end
    end
    assign preload = pl_q;
    assign so = sr_q[0];
endmodule

// [hdl/sbst_tap.sv]
`timescale 1ns/1ps
`include "sbst_map.svh"
// Test access port of the synchronous memory
module sbst_tap #(
    parameter int CHAIN_LEN = `SBST_CHAIN_LEN,
    parameter logic [2:0] REV_CODE = 3'h1,
    parameter logic [4:0] INT_CODE = 5'h11,
    parameter logic [5:0] TYPE_CODE = 6'h21,
    parameter logic [5:0] DEV_CODE = 6'h2a,
    parameter logic [10:0] MAKER_CODE = 11'h155
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_o,
    output logic tdo_oe,
    input wire logic [CHAIN_LEN-1:0] ring_in,
    output logic [CHAIN_LEN-1:0] ring_out,
    output logic mem_out_float,
    output logic ring_drive
);
    // Identity fields are arbitrary neutral values
    // fixed field codes
    localparam logic [`SBST_ID_W-1:0] ID_WORD = {REV_CODE, INT_CODE, TYPE_CODE, DEV_CODE, MAKER_CODE, 1'b1};
    // Refuse any chain length the ring does not have
    if (CHAIN_LEN != `SBST_CHAIN_LEN) begin : g_len_chk
        $error("chain length must be 89");
    end

    sbst_pkg::sbst_link_t pins;
    sbst_pkg::sbst_edge_t ev;
    sbst_pkg::sbst_state_t st_q, st_d;
    logic [`SBST_IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic [`SBST_ID_W-1:0] id_q, id_d;
    logic byp_q, byp_d;
    logic tdo_q, tdo_d, oe_q, oe_d;
    logic sel_chain, ch_cap, ch_shift, ch_upd, ch_so;

    assign pins = '{tck: tck, tms: tms, tdi: tdi};

    sbst_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pins(pins),
        .ev(ev)
    );

    always_comb begin
        st_d = st_q;
        if (ev.rise) begin
            case (st_q)
                sbst_pkg::SBST_RESET: st_d = ev.tms ? sbst_pkg::SBST_RESET : sbst_pkg::SBST_IDLE;
                sbst_pkg::SBST_IDLE: st_d = ev.tms ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_IDLE;
                sbst_pkg::SBST_SEL_DR: st_d = ev.tms ? sbst_pkg::SBST_SEL_IR : sbst_pkg::SBST_CAP_DR;
                sbst_pkg::SBST_CAP_DR: st_d = ev.tms ? sbst_pkg::SBST_EXIT1_DR : sbst_pkg::SBST_SHIFT_DR;
                sbst_pkg::SBST_SHIFT_DR: st_d = ev.tms ? sbst_pkg::SBST_EXIT1_DR : sbst_pkg::SBST_SHIFT_DR;
                sbst_pkg::SBST_EXIT1_DR: st_d = ev.tms ? sbst_pkg::SBST_UPD_DR : sbst_pkg::SBST_PAUSE_DR;
                sbst_pkg::SBST_PAUSE_DR: st_d = ev.tms ? sbst_pkg::SBST_EXIT2_DR : sbst_pkg::SBST_PAUSE_DR;
                sbst_pkg::SBST_EXIT2_DR: st_d = ev.tms ? sbst_pkg::SBST_UPD_DR : sbst_pkg::SBST_SHIFT_DR;
                sbst_pkg::SBST_UPD_DR: st_d = ev.tms ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_IDLE;
                sbst_pkg::SBST_SEL_IR: st_d = ev.tms ? sbst_pkg::SBST_RESET : sbst_pkg::SBST_CAP_IR;
                sbst_pkg::SBST_CAP_IR: st_d = ev.tms ? sbst_pkg::SBST_EXIT1_IR : sbst_pkg::SBST_SHIFT_IR;
                sbst_pkg::SBST_SHIFT_IR: st_d = ev.tms ? sbst_pkg::SBST_EXIT1_IR : sbst_pkg::SBST_SHIFT_IR;
                sbst_pkg::SBST_EXIT1_IR: st_d = ev.tms ? sbst_pkg::SBST_UPD_IR : sbst_pkg::SBST_PAUSE_IR;
                sbst_pkg::SBST_PAUSE_IR: st_d = ev.tms ? sbst_pkg::SBST_EXIT2_IR : sbst_pkg::SBST_PAUSE_IR;
                sbst_pkg::SBST_EXIT2_IR: st_d = ev.tms ? sbst_pkg::SBST_UPD_IR : sbst_pkg::SBST_SHIFT_IR;
                sbst_pkg::SBST_UPD_IR: st_d = ev.tms ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_IDLE;
                default: st_d = sbst_pkg::SBST_RESET;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= sbst_pkg::SBST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Instruction shifter and active instruction
    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d = ir_q;
        if (ev.rise) begin
            case (st_q)
                sbst_pkg::SBST_CAP_IR: ir_sh_d = `SBST_IR_CAPTURE;
                sbst_pkg::SBST_SHIFT_IR: ir_sh_d = {ev.tdi, ir_sh_q[`SBST_IR_W-1:1]};
                default: ir_sh_d = ir_sh_q;
            endcase
        end
        if (ev.fall && st_q == sbst_pkg::SBST_UPD_IR) begin
            ir_d = ir_sh_q;
        end
        if (st_q == sbst_pkg::SBST_RESET) begin
            ir_d = `SBST_OP_IDCODE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_q <= `SBST_IR_CAPTURE;
            ir_q <= `SBST_OP_IDCODE;
        end else begin
            ir_sh_q <= ir_sh_d;
            ir_q <= ir_d;
        end
    end

    always_comb begin
        sel_chain = (ir_q == `SBST_OP_EXTEST) || (ir_q == `SBST_OP_SAMPZ) || (ir_q == `SBST_OP_SAMPLE);
        ch_cap = sel_chain && ev.rise && st_q == sbst_pkg::SBST_CAP_DR;
        ch_shift = sel_chain && ev.rise && st_q == sbst_pkg::SBST_SHIFT_DR;
        ch_upd = sel_chain && ev.fall && st_q == sbst_pkg::SBST_UPD_DR;
    end

    sbst_chain #(
        .LEN(CHAIN_LEN)
    ) u_chain (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .capture(ch_cap),
        .shift(ch_shift),
        .update(ch_upd),
        .tdi(ev.tdi),
        .ring_in(ring_in),
        .preload(ring_out),
        .so(ch_so)
    );

    // Identity word and bypass bit
    always_comb begin
        id_d = id_q;
        byp_d = byp_q;
        if (ev.rise && st_q == sbst_pkg::SBST_CAP_DR) begin
            id_d = ID_WORD;
            byp_d = 1'b0;
        end else if (ev.rise && st_q == sbst_pkg::SBST_SHIFT_DR) begin
            id_d = {ev.tdi, id_q[`SBST_ID_W-1:1]};
            byp_d = ev.tdi;
        end
        if (st_q == sbst_pkg::SBST_RESET) begin
            id_d = ID_WORD;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            id_q <= ID_WORD;
            byp_q <= 1'b0;
        end else begin
            id_q <= id_d;
            byp_q <= byp_d;
        end
    end

    // TDO updates on falling TCK, floats outside shift
    always_comb begin
        tdo_d = tdo_q;
        oe_d = oe_q;
        if (ev.fall) begin
            oe_d = (st_q == sbst_pkg::SBST_SHIFT_DR) || (st_q == sbst_pkg::SBST_SHIFT_IR);
            if (st_q == sbst_pkg::SBST_SHIFT_IR) begin
                tdo_d = ir_sh_q[0];
            end else if (sel_chain) begin
                tdo_d = ch_so;
            end else if (ir_q == `SBST_OP_IDCODE) begin
                tdo_d = id_q[0];
            end else begin
                // Bypass and unused opcodes take the one-bit path
                tdo_d = byp_q;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            oe_q <= oe_d;
        end
    end

    assign tdo_o = tdo_q;
    assign tdo_oe = oe_q;

    // Memory outputs float for 000 and 010
    always_comb begin
        mem_out_float = (ir_q == `SBST_OP_EXTEST) || (ir_q == `SBST_OP_SAMPZ);
        ring_drive = (ir_q == `SBST_OP_EXTEST) && ring_out[CHAIN_LEN-1];
    end
endmodule

// [verif/sbst_tap_chk.sv]
`timescale 1ns/1ps
// Port checker for the test access port
module sbst_tap_chk #(
    parameter int CHAIN_LEN = 89
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tdo_o,
    input wire logic tdo_oe,
    input wire logic [CHAIN_LEN-1:0] ring_out,
    input wire logic mem_out_float,
    input wire logic ring_drive
);
    logic tck_q;
    logic [3:0] fall_q;
    logic [3:0] fall_d;
    logic [3:0] edge_q;
    logic [3:0] edge_d;
    // Cycles since the last TCK fall and since any TCK edge
    always_comb begin
        fall_d = (fall_q == 4'hf) ? fall_q : fall_q + 4'h1;
        edge_d = (edge_q == 4'hf) ? edge_q : edge_q + 4'h1;
        if (tck_q && !tck) begin
            fall_d = 4'h0;
        end
        if (tck_q != tck) begin
            edge_d = 4'h0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_q <= 1'b1;
            fall_q <= 4'hf;
            edge_q <= 4'hf;
        end else begin
            tck_q <= tck;
            fall_q <= fall_d;
            edge_q <= edge_d;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    drive_float_a: assert property (ring_drive |-> mem_out_float) else $error("drive outside float");
    drive_time_a: assert property ($rose(ring_drive) |-> fall_q inside {[1:6]}) else $error("drive off fall");
    tdo_time_a: assert property ($changed(tdo_o) |-> fall_q inside {[1:6]}) else $error("tdo off fall");
    oe_time_a: assert property ($changed(tdo_oe) |-> fall_q inside {[1:6]}) else $error("oe off fall");
    float_rise_a: assert property ($rose(mem_out_float) |-> fall_q inside {[1:6]}) else $error("float rise");
    float_fall_a: assert property ($fell(mem_out_float) |-> edge_q < 4'h8) else $error("float fall");
    ring_time_a: assert property ($changed(ring_out) |-> edge_q < 4'h8) else $error("latch change");
    reset_val_a: assert property ($rose(rst_n) |-> !mem_out_float && !tdo_oe) else $error("reset state");
    cover property ($rose(ring_drive));
    cover property ($rose(mem_out_float));
    cover property ($rose(tdo_oe));
endmodule
bind sbst_tap sbst_tap_chk #(.CHAIN_LEN(CHAIN_LEN)) i_chk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tck(tck),
    .tdo_o(tdo_o),
    .tdo_oe(tdo_oe),
    .ring_out(ring_out),
    .mem_out_float(mem_out_float),
    .ring_drive(ring_drive)
);

// [verif/sbst_host.sv]
`timescale 1ns/1ps
// Boundary-scan controller model on the link pins
module sbst_host (
    input wire logic sys_clk,
    input wire logic tdo_o,
    input wire logic tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One TCK period; TDO taken before the next fall, unknown when undriven
    // state walk
    task automatic step(input logic m, input logic d, output logic o);
        @(negedge sys_clk);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (4) @(negedge sys_clk);
        tck = 1'b1;
        repeat (3) @(negedge sys_clk);
        o = tdo_oe ? tdo_o : 1'bx;
        tdi = ~d;
    endtask
    // TMS sequence, first bit first
    task automatic walk(input logic [7:0] seq, input int n);
        logic b;
        for (int i = 0; i < n; i++) begin
            step(seq[i], 1'b0, b);
        end
    endtask
    // Shift n bits, leave through update to idle
    // update applies
    task automatic scan(input logic [127:0] din, input int n, output logic [127:0] dout);
        logic b;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        walk(8'h01, 2);
    endtask
    // Idle to Shift-IR, then load the opcode
    task automatic load_ir(input logic [2:0] op);
        logic [127:0] x;
        walk(8'h03, 4);
        scan(128'(op), 3, x);
    endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
// Self-checking bench for the test access port
module testbench;
    localparam int LEN = 89;
    localparam logic [127:0] MASK = (128'h1 << 90) - 128'h1;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic tck, tms, tdi, tdo_o, tdo_oe, mem_out_float, ring_drive, chain;
    logic [LEN-1:0] ring_in = 89'ha51c3e77d29b406f18e2c5;
    logic [LEN-1:0] ring_out;
    logic [127:0] din = 128'h3a5c39e174b2df0681234c5;
    logic [127:0] dout, cap;
    logic [2:0] op;
    logic [3:0] plan [11] = '{4'h8, 4'h0, 4'h1, 4'h2, 4'h7, 4'h4, 4'h2, 4'h1, 4'h7, 4'h0, 4'h9};
    logic [31:0] id_word = {3'h5, 5'h0e, 6'h13, 6'h2c, 11'h2a7, 1'b1};
    int len;
    int fails = 0;
    int num_checks = 0;
    always #25 sys_clk = ~sys_clk;
    // Identity fields are arbitrary values
    sbst_tap #(.CHAIN_LEN(LEN), .REV_CODE(3'h5), .INT_CODE(5'h0e), .TYPE_CODE(6'h13),
        .DEV_CODE(6'h2c), .MAKER_CODE(11'h2a7)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .ring_in(ring_in),
        .ring_out(ring_out), .mem_out_float(mem_out_float), .ring_drive(ring_drive));
    sbst_host i_host (.sys_clk(sys_clk), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #2000000;
        fails++;
        test_done();
    end
    // Each opcode, then reset walk; 90 bits read through each path
    initial begin
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        i_host.walk(8'h00, 1); // leave reset state for idle
        for (int k = 0; k < 11; k++) begin
            if (plan[k] == 4'h9) begin
                i_host.walk(8'h1f, 6);
            end
            if (plan[k] < 4'h8) begin
                i_host.load_ir(plan[k][2:0]);
            end
            op = (plan[k] > 4'h7) ? 3'h1 : plan[k][2:0];
            chain = (op == 3'h0 || op == 3'h2 || op == 3'h4);
            len = chain ? LEN : (op == 3'h1) ? 32 : 1;
            cap = chain ? 128'(ring_in) : (op == 3'h1) ? 128'(id_word) : '0;
            check("float", mem_out_float, op == 3'h0 || op == 3'h2);
            check("oe idle", tdo_oe, 1'b0);
            i_host.walk(8'h01, 3);
            i_host.scan(din, 90, dout);
            check("scan", dout, (cap | din << len) & MASK);
            if (chain) begin
                check("preload", ring_out, din[89:1]);
            end
            check("drive", ring_drive, op == 3'h0 && din[89]);
        end
        test_done();
    end
endmodule
